// [core/plrc_top.sv]
// pll routing, charge pump and reference buffer control
`timescale 1ns/1ps
module plrc_top (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    // register port
    input  wire logic [plrc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                    reg_wr_en,
    input  wire logic                    reg_rd_en,
    input  wire logic [plrc_pkg::DATA_W-1:0] reg_wr_data,
    output logic      [plrc_pkg::DATA_W-1:0] reg_rd_data,
    output logic                         reg_rd_valid,
    // divider outputs entering the detector, asynchronous
    input  wire logic                    ref_div_in,
    input  wire logic                    fb_div_in,
    // pll power and routing
    output logic                         pll_power_down,
    output logic [2:0]                   vco_div_ratio,
    output logic                         dist_bypass_vco_div,
    output logic                         prescaler_feed_en,
    // charge pump
    output logic                         cp_up,
    output logic                         cp_down,
    output logic                         cp_hiz,
    output logic [2:0]                   cp_current_code,
    output logic [12:0]                  cp_current_ua,
    // reference buffers
    output logic                         ref_diff_buf_en,
    output logic                         first_se_ref_buf_en,
    output logic                         second_se_ref_buf_en
);
    import plrc_pkg::*;

    // register storage
    logic [DATA_W-1:0] pll_ctrl_r;
    logic [DATA_W-1:0] pfd_ab_r;
    logic [DATA_W-1:0] ref_ctrl_r;
    logic [DATA_W-1:0] vco_div_r;
    logic [DATA_W-1:0] dist_src_r;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic              rd_valid_r;

    // address decode
    logic hit_pll_w;
    logic hit_ab_w;
    logic hit_ref_w;
    logic hit_vdiv_w;
    logic hit_dist_w;

    // per-register write strobes
    logic wr_pll_w;
    logic wr_ab_w;
    logic wr_ref_w;
    logic wr_vdiv_w;
    logic wr_dist_w;

    // input synchronisers, three stages each
    logic [2:0] ref_sync_r;
    logic [2:0] fb_sync_r;
    logic       ref_lvl_r;
    logic       fb_lvl_r;
    logic       ref_lvl_nxt;
    logic       fb_lvl_nxt;

    // decoded fields
    logic [1:0]    pd_field_w;
    logic          pll_on_w;
    logic          polarity_neg_w;
    plrc_cp_mode_t cp_mode_w;
    logic [2:0]    vdiv_code_w;
    logic          bypass_w;
    logic          diff_sel_w;
    logic          se1_pd_w;
    logic          se2_pd_w;

    // detector results
    logic pump_up_w;
    logic pump_dn_w;

    // shared gate of the single-ended pair
    logic se_allowed_w;

    plrc_pfd_if pfd_bus ();

    // ratio lookup, used only by the vco_div_ratio output
    function automatic logic [2:0] vdiv_ratio(input logic [2:0] code);
        if (code > VDIV_CODE_MAX) begin
            vdiv_ratio = VDIV_MIN_RATIO + VDIV_CODE_MAX;
        end else begin
            vdiv_ratio = VDIV_MIN_RATIO + code;
        end
    endfunction : vdiv_ratio

    // masked register update, reserved bits stay zero
    function automatic logic [DATA_W-1:0] masked(input logic [DATA_W-1:0] val,
                                                 input logic [DATA_W-1:0] msk);
        masked = val & msk;
    endfunction : masked

    // address decode
    assign hit_pll_w  = (reg_addr == OFS_PLL_CTRL);
    assign hit_ab_w   = (reg_addr == OFS_PFD_AB);
    assign hit_ref_w  = (reg_addr == OFS_REF_CTRL);
    assign hit_vdiv_w = (reg_addr == OFS_VCO_DIV);
    assign hit_dist_w = (reg_addr == OFS_DIST_SRC);

    // write strobes, one per register
    assign wr_pll_w  = reg_wr_en && hit_pll_w;
    assign wr_ab_w   = reg_wr_en && hit_ab_w;
    assign wr_ref_w  = reg_wr_en && hit_ref_w;
    assign wr_vdiv_w = reg_wr_en && hit_vdiv_w;
    assign wr_dist_w = reg_wr_en && hit_dist_w;

    // pll control; asynchronous reset leaves the pll powered off
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pll_ctrl_r <= RST_PLL_CTRL;
        end else if (wr_pll_w) begin
            pll_ctrl_r <= masked(reg_wr_data, MSK_PLL_CTRL);
        end
    end

    // antibacklash width and pump current
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pfd_ab_r <= RST_PFD_AB;
        end else if (wr_ab_w) begin
            pfd_ab_r <= masked(reg_wr_data, MSK_PFD_AB);
        end
    end

    // reference control; both single-ended buffers start powered down
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ref_ctrl_r <= RST_REF_CTRL;
        end else if (wr_ref_w) begin
            ref_ctrl_r <= masked(reg_wr_data, MSK_REF_CTRL);
        end
    end

    // vco divider code, divide by four after reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            vco_div_r <= RST_VCO_DIV;
        end else if (wr_vdiv_w) begin
            vco_div_r <= masked(reg_wr_data, MSK_VCO_DIV);
        end
    end

    // distribution source, vco divider path after reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dist_src_r <= RST_DIST_SRC;
        end else if (wr_dist_w) begin
            dist_src_r <= masked(reg_wr_data, MSK_DIST_SRC);
        end
    end

    // read mux, unmapped addresses answer zero
    always_comb begin
        rd_data_nxt = '0;
        case (1'b1)
            hit_pll_w:  rd_data_nxt = pll_ctrl_r;
            hit_ab_w:   rd_data_nxt = pfd_ab_r;
            hit_ref_w:  rd_data_nxt = ref_ctrl_r;
            hit_vdiv_w: rd_data_nxt = vco_div_r;
            hit_dist_w: rd_data_nxt = dist_src_r;
            default:    rd_data_nxt = '0;
        endcase
    end

    // read data registered one cycle after the request
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_r  <= '0;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_en;
            if (reg_rd_en) begin
                rd_data_r <= rd_data_nxt;
            end
        end
    end

    assign reg_rd_data  = rd_data_r;
    assign reg_rd_valid = rd_valid_r;

    // field extraction
    assign pd_field_w     = pll_ctrl_r[PD_MSB:PD_LSB];
    assign polarity_neg_w = pll_ctrl_r[POL_BIT];
    assign cp_mode_w      = plrc_cp_mode_t'(pll_ctrl_r[CPM_MSB:CPM_LSB]);
    assign vdiv_code_w    = vco_div_r[VDIV_MSB:VDIV_LSB];
    assign bypass_w       = dist_src_r[BYP_BIT];
    assign diff_sel_w     = ref_ctrl_r[REF_DIFF_BIT];
    assign se1_pd_w       = ref_ctrl_r[REF_PD1_BIT];
    assign se2_pd_w       = ref_ctrl_r[REF_PD2_BIT];

    // only the normal code runs the pll; the spare codes are kept safe as off
    assign pll_on_w       = (pd_field_w == PD_NORMAL);
    assign pll_power_down = !pll_on_w;

    // routing of the clock input to the distribution section
    assign vco_div_ratio       = vdiv_ratio(vdiv_code_w);
    assign dist_bypass_vco_div = bypass_w;
    assign prescaler_feed_en   = pll_on_w && !bypass_w;

    // three-stage synchroniser, a change counts once stages two and three agree
    assign ref_lvl_nxt = (ref_sync_r[1] == ref_sync_r[2]) ? ref_sync_r[2] : ref_lvl_r;
    assign fb_lvl_nxt  = (fb_sync_r[1] == fb_sync_r[2]) ? fb_sync_r[2] : fb_lvl_r;

    // reference stages; level resets low like the idle pin, so no false edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ref_sync_r <= 3'h0;
            ref_lvl_r  <= 1'b0;
        end else begin
            ref_sync_r <= {ref_sync_r[1:0], ref_div_in};
            ref_lvl_r  <= ref_lvl_nxt;
        end
    end

    // feedback stages, same filter
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fb_sync_r <= 3'h0;
            fb_lvl_r  <= 1'b0;
        end else begin
            fb_sync_r <= {fb_sync_r[1:0], fb_div_in};
            fb_lvl_r  <= fb_lvl_nxt;
        end
    end

    // rising edges of the filtered levels drive the detector
    assign pfd_bus.enable   = pll_on_w;
    assign pfd_bus.ab_code  = pfd_ab_r[AB_MSB:AB_LSB];
    assign pfd_bus.ref_rise = ref_lvl_nxt && !ref_lvl_r;
    assign pfd_bus.fb_rise  = fb_lvl_nxt && !fb_lvl_r;

    plrc_pfd u_pfd (
        .clock (clock),
        .rst_b (rst_b),
        .pif   (pfd_bus.pfd)
    );

    // negative sense just swaps the two commands
    assign pump_up_w = polarity_neg_w ? pfd_bus.down : pfd_bus.up;
    assign pump_dn_w = polarity_neg_w ? pfd_bus.up : pfd_bus.down;

    // pump mode; a powered-down pll never drives the loop filter
    always_comb begin
        cp_up   = 1'b0;
        cp_down = 1'b0;
        cp_hiz  = 1'b1;
        if (pll_on_w) begin
            case (cp_mode_w)
                PLRC_CP_NORMAL: begin
                    cp_up   = pump_up_w;
                    cp_down = pump_dn_w;
                    cp_hiz  = 1'b0;
                end
                PLRC_CP_UP: begin
                    cp_up   = 1'b1;
                    cp_hiz  = 1'b0;
                end
                PLRC_CP_DOWN: begin
                    cp_down = 1'b1;
                    cp_hiz  = 1'b0;
                end
                PLRC_CP_HIZ: begin
                    cp_hiz  = 1'b1;
                end
                default: begin
                    cp_hiz  = 1'b1;
                end
            endcase
        end
    end

    // pump current, exact lsb scales with the external bias resistor
    assign cp_current_code = pfd_ab_r[ICP_MSB:ICP_LSB];
    assign cp_current_ua   = 13'(ICP_STEP_UA * ({10'h0, cp_current_code} + 13'h1));

    // reference buffer power gating
    assign se_allowed_w         = pll_on_w && !diff_sel_w;
    assign ref_diff_buf_en      = pll_on_w && diff_sel_w;
    assign first_se_ref_buf_en  = se_allowed_w && !se1_pd_w;
    assign second_se_ref_buf_en = se_allowed_w && !se2_pd_w;

endmodule : plrc_top

// [include/plrc_pkg.sv]
// constants for pll routing and reference input control
package plrc_pkg;

    // register bus geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_PLL_CTRL  = 9'h010;
    localparam logic [ADDR_W-1:0] OFS_PFD_AB    = 9'h017;
    localparam logic [ADDR_W-1:0] OFS_REF_CTRL  = 9'h01c;
    localparam logic [ADDR_W-1:0] OFS_VCO_DIV   = 9'h1e0;
    localparam logic [ADDR_W-1:0] OFS_DIST_SRC  = 9'h1e1;

    // reset values
    localparam logic [DATA_W-1:0] RST_PLL_CTRL  = 8'h01;
    localparam logic [DATA_W-1:0] RST_PFD_AB    = 8'h00;
    localparam logic [DATA_W-1:0] RST_REF_CTRL  = 8'h06;
    localparam logic [DATA_W-1:0] RST_VCO_DIV   = 8'h02;
    localparam logic [DATA_W-1:0] RST_DIST_SRC  = 8'h00;

    // field positions in the pll control register
    localparam int PD_LSB      = 0;
    localparam int PD_MSB      = 1;
    localparam int CPM_LSB     = 4;
    localparam int CPM_MSB     = 6;
    localparam int POL_BIT     = 7;
    // field positions in the antibacklash register
    localparam int AB_LSB      = 0;
    localparam int AB_MSB      = 1;
    localparam int ICP_LSB     = 2;
    localparam int ICP_MSB     = 4;
    // field positions in the reference control register
    localparam int REF_DIFF_BIT = 0;
    localparam int REF_PD1_BIT  = 1;
    localparam int REF_PD2_BIT  = 2;
    // vco divider and distribution source fields
    localparam int VDIV_LSB    = 0;
    localparam int VDIV_MSB    = 2;
    localparam int BYP_BIT     = 0;

    // writable bit masks, the rest reads as zero
    localparam logic [DATA_W-1:0] MSK_PLL_CTRL  = 8'hf3;
    localparam logic [DATA_W-1:0] MSK_PFD_AB    = 8'h1f;
    localparam logic [DATA_W-1:0] MSK_REF_CTRL  = 8'h07;
    localparam logic [DATA_W-1:0] MSK_VCO_DIV   = 8'h07;
    localparam logic [DATA_W-1:0] MSK_DIST_SRC  = 8'h01;

    // power-down field codes
    localparam logic [1:0] PD_NORMAL  = 2'h0;
    localparam logic [1:0] PD_ASYNC   = 2'h1;

    // vco divider codes and resulting ratios
    localparam logic [2:0] VDIV_CODE_MAX = 3'h4;
    localparam logic [2:0] VDIV_MIN_RATIO = 3'h2;

    // charge pump mode codes
    typedef enum logic [2:0] {
        PLRC_CP_HIZ    = 3'h0,
        PLRC_CP_UP     = 3'h1,
        PLRC_CP_DOWN   = 3'h2,
        PLRC_CP_NORMAL = 3'h3
    } plrc_cp_mode_t;

    // charge pump current in microamps
    localparam logic [12:0] ICP_STEP_UA = 13'h0258;

    // antibacklash count limit for code zero, the hold itself lasts two cycles
    localparam logic [2:0] AB_BASE_CYC = 3'h1;

endpackage : plrc_pkg

// [include/plrc_pfd_if.sv]
// carrier between the control core and the phase frequency detector
`timescale 1ns/1ps
interface plrc_pfd_if;
    logic       enable;
    logic [1:0] ab_code;
    logic       ref_rise;
    logic       fb_rise;
    logic       up;
    logic       down;

    modport ctrl (output enable, output ab_code, output ref_rise, output fb_rise,
                  input up, input down);
    modport pfd  (input enable, input ab_code, input ref_rise, input fb_rise,
                  output up, output down);
endinterface : plrc_pfd_if

// [core/plrc_pfd.sv]
// phase frequency detector with antibacklash hold
`timescale 1ns/1ps
module plrc_pfd (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // detector carrier
    plrc_pfd_if.pfd   pif
);
    import plrc_pkg::*;

    logic       up_r;
    logic       up_nxt;
    logic       dn_r;
    logic       dn_nxt;
    logic [2:0] ab_cnt_r;
    logic [2:0] ab_cnt_nxt;
    logic       both_w;
    logic       ab_done_w;
    logic [2:0] ab_len_w;

    // hold both outputs a little while so there is no dead zone near lock
    function automatic logic [2:0] ab_cycles(input logic [1:0] code);
        ab_cycles = AB_BASE_CYC + {1'b0, code};
    endfunction : ab_cycles

    assign ab_len_w  = ab_cycles(pif.ab_code);
    assign both_w    = up_r && dn_r;
    assign ab_done_w = both_w && (ab_cnt_r >= ab_len_w);

    // new edges win over the antibacklash clear
    assign up_nxt = !pif.enable ? 1'b0 : (pif.ref_rise || (up_r && !ab_done_w));
    assign dn_nxt = !pif.enable ? 1'b0 : (pif.fb_rise  || (dn_r && !ab_done_w));
    assign ab_cnt_nxt = both_w && !ab_done_w ? ab_cnt_r + 3'h1 : 3'h0;

    // detector state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            up_r     <= 1'b0;
            dn_r     <= 1'b0;
            ab_cnt_r <= 3'h0;
        end else begin
            up_r     <= up_nxt;
            dn_r     <= dn_nxt;
            ab_cnt_r <= ab_cnt_nxt;
        end
    end

    assign pif.up   = up_r;
    assign pif.down = dn_r;

endmodule : plrc_pfd

// [testbench/plrc_monitor.sv]
// assertion checker for the pll routing and reference control block
`timescale 1ns/1ps
module plrc_monitor (
    // clock and reset
    input wire logic                        clock,
    input wire logic                        rst_b,
    // register port
    input wire logic [plrc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                        reg_wr_en,
    input wire logic [plrc_pkg::DATA_W-1:0] reg_wr_data,
    // routing and pump
    input wire logic                        pll_power_down,
    input wire logic [2:0]                  vco_div_ratio,
    input wire logic                        dist_bypass_vco_div,
    input wire logic                        prescaler_feed_en,
    input wire logic                        cp_up,
    input wire logic                        cp_down,
    input wire logic                        cp_hiz,
    input wire logic [2:0]                  cp_current_code,
    input wire logic [12:0]                 cp_current_ua,
    // reference buffers
    input wire logic                        ref_diff_buf_en,
    input wire logic                        first_se_ref_buf_en,
    input wire logic                        second_se_ref_buf_en
);
    import plrc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // write decode, seen from the pins only
    wire logic wr_pll  = reg_wr_en && reg_addr == OFS_PLL_CTRL;
    wire logic wr_vdiv = reg_wr_en && reg_addr == OFS_VCO_DIV;
    wire logic wr_dist = reg_wr_en && reg_addr == OFS_DIST_SRC;
    wire logic wr_bit0 = reg_wr_data[BYP_BIT];
    property p_rst_dflt;
        $rose(rst_b) |-> pll_power_down && vco_div_ratio == 3'h4 && !dist_bypass_vco_div;
    endproperty
    a_rst_dflt: assert property (p_rst_dflt) else $error("reset defaults wrong");
    property p_pd_wr;
        logic [1:0] d;
        (wr_pll, d = reg_wr_data[1:0]) |=> pll_power_down == (d != PD_NORMAL);
    endproperty
    a_pd_wr: assert property (p_pd_wr) else $error("power-down code ignored");
    property p_div_wr;
        logic [2:0] d;
        (wr_vdiv, d = reg_wr_data[2:0]) |=>
            vco_div_ratio == ((d > VDIV_CODE_MAX) ? 3'h6 : d + VDIV_MIN_RATIO);
    endproperty
    a_div_wr: assert property (p_div_wr) else $error("divide ratio wrong");
    property p_div_rng;
        vco_div_ratio inside {[3'h2:3'h6]};
    endproperty
    a_div_rng: assert property (p_div_rng) else $error("divide ratio out of range");
    property p_byp_wr;
        wr_dist |=> dist_bypass_vco_div == $past(wr_bit0);
    endproperty
    a_byp_wr: assert property (p_byp_wr) else $error("bypass bit not taken");
    property p_byp_hold;
        !wr_dist |=> $stable(dist_bypass_vco_div);
    endproperty
    a_byp_hold: assert property (p_byp_hold) else $error("bypass moved unasked");
    property p_feed;
        prescaler_feed_en == (!pll_power_down && !dist_bypass_vco_div);
    endproperty
    a_feed: assert property (p_feed) else $error("prescaler feed wrong");
    property p_icp;
        cp_current_ua == ICP_STEP_UA * ({10'h000, cp_current_code} + 13'h0001);
    endproperty
    a_icp: assert property (p_icp) else $error("pump current wrong");
    property p_diff;
        ref_diff_buf_en |-> !pll_power_down && !first_se_ref_buf_en && !second_se_ref_buf_en;
    endproperty
    a_diff: assert property (p_diff) else $error("differential buffer conflict");
    property p_se;
        (first_se_ref_buf_en || second_se_ref_buf_en) |-> !pll_power_down;
    endproperty
    a_se: assert property (p_se) else $error("single-ended buffer on while down");
    property p_hiz;
        cp_hiz |-> !cp_up && !cp_down;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pump drives while floating");
    property p_ab;
        $rose(cp_up && cp_down) |-> ##[1:5] !(cp_up && cp_down);
    endproperty
    a_ab: assert property (p_ab) else $error("antibacklash too long");
endmodule : plrc_monitor

bind plrc_top plrc_monitor mon_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .pll_power_down(pll_power_down),
    .vco_div_ratio(vco_div_ratio), .dist_bypass_vco_div(dist_bypass_vco_div),
    .prescaler_feed_en(prescaler_feed_en), .cp_up(cp_up), .cp_down(cp_down),
    .cp_hiz(cp_hiz), .cp_current_code(cp_current_code), .cp_current_ua(cp_current_ua),
    .ref_diff_buf_en(ref_diff_buf_en), .first_se_ref_buf_en(first_se_ref_buf_en),
    .second_se_ref_buf_en(second_se_ref_buf_en));

// [testbench/plrc_vco_model.sv]
// external oscillator, loop filter and feedback divider model
`timescale 1ns/1ps
module plrc_vco_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // stall control and pump commands
    input wire logic run,
    input wire logic cp_up,
    input wire logic cp_down,
    // divided feedback
    output logic     fb_div_in
);
    logic [4:0] half_r;
    logic [4:0] cnt_r;
    // clamped integrator; floor keeps feedback edges well apart
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            half_r <= 5'h0c;
        end else if (cp_up && !cp_down && half_r > 5'h08) begin
            half_r <= half_r - 5'h01;
        end else if (cp_down && !cp_up && half_r < 5'h1e) begin
            half_r <= half_r + 5'h01;
        end
    end
    // stalled divider rests low, first edge on restart
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fb_div_in <= 1'b0;
            cnt_r     <= 5'h00;
        end else if (!run) begin
            fb_div_in <= 1'b0;
            cnt_r     <= 5'h00;
        end else if (cnt_r == 5'h00) begin
            fb_div_in <= !fb_div_in;
            cnt_r     <= half_r;
        end else begin
            cnt_r <= cnt_r - 5'h01;
        end
    end
endmodule : plrc_vco_model

// [testbench/plrc_tb_top.sv]
// self-checking bench for pll routing and reference control
`timescale 1ns/1ps
module plrc_tb_top;
    import plrc_pkg::*;
    localparam logic [ADDR_W-1:0] ADR_T [5] = '{OFS_PLL_CTRL, OFS_PFD_AB, OFS_REF_CTRL,
                                                OFS_VCO_DIV, OFS_DIST_SRC};
    localparam logic [DATA_W-1:0] RST_T [5] = '{RST_PLL_CTRL, RST_PFD_AB, RST_REF_CTRL,
                                                RST_VCO_DIV, RST_DIST_SRC};
    localparam logic [DATA_W-1:0] MSK_T [5] = '{MSK_PLL_CTRL, MSK_PFD_AB, MSK_REF_CTRL,
                                                MSK_VCO_DIV, MSK_DIST_SRC};
    // hiz, up, down per pump mode
    localparam logic [2:0] CP_T [8] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h4, 3'h4, 3'h4, 3'h4};
    logic              clock = 1'b0;
    logic              rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 9'h000;
    logic              reg_wr_en = 1'b0;
    logic              reg_rd_en = 1'b0;
    logic [DATA_W-1:0] reg_wr_data = 8'h00;
    logic              ref_div_in = 1'b0;
    logic              run = 1'b0;
    logic [DATA_W-1:0] reg_rd_data;
    logic [2:0]        vco_div_ratio, cp_current_code;
    logic [12:0]       cp_current_ua;
    logic              reg_rd_valid, fb_div_in, pll_power_down, dist_bypass_vco_div;
    logic              prescaler_feed_en, cp_up, cp_down, cp_hiz;
    logic              ref_diff_buf_en, first_se_ref_buf_en, second_se_ref_buf_en;
    int                n_fail = 0;
    int                n_tests = 0;
    int                cyc = 0;
    int                n;
    always #20 clock = !clock;
    plrc_top dut_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .ref_div_in(ref_div_in),
        .fb_div_in(fb_div_in), .pll_power_down(pll_power_down),
        .vco_div_ratio(vco_div_ratio), .dist_bypass_vco_div(dist_bypass_vco_div),
        .prescaler_feed_en(prescaler_feed_en), .cp_up(cp_up), .cp_down(cp_down),
        .cp_hiz(cp_hiz), .cp_current_code(cp_current_code), .cp_current_ua(cp_current_ua),
        .ref_diff_buf_en(ref_diff_buf_en), .first_se_ref_buf_en(first_se_ref_buf_en),
        .second_se_ref_buf_en(second_se_ref_buf_en));
    plrc_vco_model vco_u (.clock(clock), .rst_b(rst_b), .run(run), .cp_up(cp_up),
        .cp_down(cp_down), .fb_div_in(fb_div_in));
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step;
        @(posedge clock);
        #1;
    endtask : step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= 1'b1;
        @(posedge clock);
        reg_wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clock);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        #1;
        chk(reg_rd_valid, 13'h0001);
        chk(reg_rd_data, exp);
    endtask : rd
    task automatic do_reset;
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
    endtask : do_reset
    // register table and pin defaults after any reset
    task automatic chk_defaults;
        for (int i = 0; i < 5; i++) begin
            rd(ADR_T[i], RST_T[i]);
        end
        chk({pll_power_down, vco_div_ratio, dist_bypass_vco_div}, 13'h0018);
        chk({ref_diff_buf_en, first_se_ref_buf_en, second_se_ref_buf_en}, 13'h0000);
    endtask : chk_defaults
    task automatic tally_and_finish;
        $display("mismatches %0d, comparisons %0d", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard, under a thousand cycles expected
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        do_reset();
        chk_defaults();
        // unmapped place and reserved bits
        wr(9'h1ff, 8'hff);
        rd(9'h1ff, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(ADR_T[i], 8'hff);
            rd(ADR_T[i], MSK_T[i]);
        end
        for (int c = 0; c < 8; c++) begin
            wr(OFS_VCO_DIV, 8'(c));
            #1 chk(vco_div_ratio, (c <= 4) ? 13'(c + 2) : 13'h0006);
        end
        // every power-down code on both routings
        for (int b = 0; b < 2; b++) begin
            for (int p = 0; p < 4; p++) begin
                wr(OFS_DIST_SRC, 8'(b));
                wr(OFS_PLL_CTRL, 8'(p));
                #1 chk(pll_power_down, 13'(p != 0));
                chk(dist_bypass_vco_div, 13'(b));
                chk(prescaler_feed_en, 13'(p == 0 && b == 0));
            end
        end
        for (int c = 0; c < 8; c++) begin
            wr(OFS_PFD_AB, 8'(c << 2));
            #1 chk(cp_current_ua, 13'(600 * (c + 1)));
            chk(cp_current_code, 13'(c));
        end
        for (int p = 0; p < 2; p++) begin
            wr(OFS_PLL_CTRL, 8'(p));
            for (int r = 0; r < 8; r++) begin
                wr(OFS_REF_CTRL, 8'(r));
                #1 chk(ref_diff_buf_en, 13'(p == 0 && r[0]));
                chk(first_se_ref_buf_en, 13'(p == 0 && !r[0] && !r[1]));
                chk(second_se_ref_buf_en, 13'(p == 0 && !r[0] && !r[2]));
            end
        end
        // every pump mode under both polarities, no detector edges
        for (int k = 0; k < 16; k++) begin
            wr(OFS_PLL_CTRL, 8'(k << 4));
            #1 chk({cp_hiz, cp_up, cp_down}, 13'(CP_T[k[2:0]]));
        end
        // detector: reference first, then feedback; all widths, both senses
        wr(OFS_REF_CTRL, 8'h01);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_PFD_AB, 8'(k % 4));
            wr(OFS_PLL_CTRL, 8'((k / 4) << 7) | 8'h30);
            ref_div_in <= 1'b1;
            for (int w = 0; w < 8 && !(cp_up || cp_down); w++) step();
            chk({cp_up, cp_down}, (k < 4) ? 13'h0002 : 13'h0001);
            @(posedge clock);
            run <= 1'b1;
            for (int w = 0; w < 60 && !(cp_up && cp_down); w++) step();
            n = 0;
            while (cp_up && cp_down && n < 9) begin
                n++;
                step();
            end
            chk(13'(n), 13'(k % 4 + 2));
            @(posedge clock);
            run        <= 1'b0;
            ref_div_in <= 1'b0;
            repeat (6) step();
        end
        // reset in mid-run brings every default back
        do_reset();
        chk_defaults();
        tally_and_finish();
    end
endmodule : plrc_tb_top
